// >>> pkg/cc_conn_pkg.sv
// Constants and types for the port connection state machine.
// Assumes a single 40 MHz clock domain; no software-visible registers.
package cc_conn_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   // Debounce time in microseconds; plain default, shortened in simulation
   localparam int unsigned DEBOUNCE_US = 150;
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000));
   // Dwell in each unattached role while toggling, in microseconds
   localparam int unsigned TOGGLE_US = 50;
   localparam int unsigned TOGGLE_CYC = (TOGGLE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CNT_W = 16;

   // Port kinds
   localparam logic [1:0] KIND_SRC = 2'h0;
   localparam logic [1:0] KIND_SNK = 2'h1;
   localparam logic [1:0] KIND_DRP = 2'h2;

   // Try mechanism choice
   localparam logic [1:0] TRY_NONE = 2'h0;
   localparam logic [1:0] TRY_SRC = 2'h1;
   localparam logic [1:0] TRY_SNK = 2'h2;

   typedef enum logic [3:0] {
      ST_UNATT_SNK = 4'h0,
      ST_WAIT_SNK = 4'h1,
      ST_ATT_SNK = 4'h2,
      ST_UNATT_SRC = 4'h3,
      ST_WAIT_SRC = 4'h4,
      ST_ATT_SRC = 4'h5,
      ST_TRY_SRC = 4'h6,
      ST_TRY_SNK = 4'h7
   } conn_state_t;

   // Termination presented on CC
   localparam logic [1:0] TERM_OPEN = 2'h0;
   localparam logic [1:0] TERM_PULLUP = 2'h1;
   localparam logic [1:0] TERM_PULLDOWN = 2'h2;
endpackage

// >>> verification/cc_far_port.sv
// Model of the port at the far end of the cable, sink or source.
// Assumes bench commands change just after the clock edge.
`timescale 1ns/1ps
module cc_far_port
   import cc_conn_pkg::*;
#(
   parameter int unsigned VBUS_DELAY = 3
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic plug_in,
   input wire logic src_role_in,
   input wire logic supply_in,
   input wire logic [1:0] level_in,
   input wire logic [1:0] dut_term_in,
   output logic pulldown_out,
   output logic pullup_out,
   output logic vbus_out,
   output logic [1:0] rd_level_out
);
   logic flip_q;
   logic flip_d;
   logic vbus_q;
   logic vbus_d;
   logic [3:0] wait_q;
   logic [3:0] wait_d;
   logic src_now;
   logic hold;
   assign src_now = plug_in && src_role_in && !flip_q;
   assign hold = src_now && dut_term_in == TERM_PULLDOWN;
   always_comb begin
      // A powered source that then sees a pull-up gives way and turns sink
      flip_d = plug_in && (flip_q || (src_role_in && vbus_q && dut_term_in == TERM_PULLUP));
      // VBUS_DELAY sets a prompt or a slow supply
      wait_d = hold ? wait_q + {3'h0, wait_q < 4'(VBUS_DELAY)} : 4'h0;
      vbus_d = hold && supply_in && wait_q == 4'(VBUS_DELAY);
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flip_q <= 1'b0;
         vbus_q <= 1'b0;
         wait_q <= 4'h0;
      end else begin
         flip_q <= flip_d;
         vbus_q <= vbus_d;
         wait_q <= wait_d;
      end
   end
   assign pulldown_out = plug_in && !src_now;
   assign pullup_out = src_now;
   assign vbus_out = vbus_q;
   assign rd_level_out = src_now ? level_in : 2'h0;
endmodule

// >>> verification/cc_port_conn_sva.sv
// Checker for the port connection state machine.
// Bound to cc_port_conn; sees its ports only.
`timescale 1ns/1ps
module cc_port_conn_sva
   import cc_conn_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int unsigned TOGGLE_CYCLES = TOGGLE_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic [1:0] port_kind_in,
   input wire logic [1:0] try_mode_in,
   input wire logic usb2_simple_in,
   input wire logic cc_pulldown_seen_in,
   input wire logic cc_pullup_seen_in,
   input wire logic [1:0] cc_rd_level_in,
   input wire logic vbus_present_in,
   input wire logic [1:0] rp_limit_in,
   input wire logic [3:0] state_out,
   input wire logic [1:0] cc_term_out,
   input wire logic [1:0] rp_level_out,
   input wire logic [1:0] sink_current_out,
   input wire logic vbus_en_out,
   input wire logic vconn_en_out,
   input wire logic attached_out
);
   ////////////////////////////////////////
   // Enabled edges in the current state; lags a state change by one edge
   logic [15:0] dwell_q;
   logic [15:0] dwell_d;
   logic [3:0] prev_q;
   always_comb begin
      dwell_d = dwell_q + {15'h0000, clk_en_in};
      if (state_out != prev_q) begin
         dwell_d = 16'h0000;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dwell_q <= 16'h0000;
         prev_q <= 4'h0;
      end else begin
         dwell_q <= dwell_d;
         prev_q <= state_out;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_wait_src_entry: assert property (
      state_out == ST_UNATT_SRC && cc_pulldown_seen_in && clk_en_in |=> state_out == ST_WAIT_SRC)
      else $error("source wait not entered");
   a_src_debounce: assert property (
      state_out == ST_ATT_SRC && $past(state_out) == ST_WAIT_SRC |-> dwell_q >= DEBOUNCE_CYCLES)
      else $error("source attached early");
   a_snk_debounce: assert property (
      state_out == ST_ATT_SNK && $past(state_out) == ST_WAIT_SNK
      |-> dwell_q >= DEBOUNCE_CYCLES && $past(vbus_present_in))
      else $error("sink attached early");
   a_supply_follow: assert property (
      vbus_en_out == (state_out == ST_ATT_SRC) && vconn_en_out == vbus_en_out)
      else $error("supplies wrong");
   a_rp_follow: assert property (
      state_out == ST_ATT_SRC && clk_en_in ##1 state_out == ST_ATT_SRC
      |-> rp_level_out == $past(rp_limit_in))
      else $error("rp not following");
   a_vrd_follow: assert property (
      state_out == ST_ATT_SNK && clk_en_in ##1 state_out == ST_ATT_SNK
      |-> sink_current_out == $past(cc_rd_level_in))
      else $error("sink level not following");
   a_snk_detach: assert property (
      state_out == ST_ATT_SNK && !vbus_present_in && clk_en_in |=> state_out == ST_UNATT_SNK)
      else $error("sink detach missed");
   a_drp_detach: assert property (
      state_out == ST_ATT_SRC && port_kind_in == KIND_DRP && !cc_pulldown_seen_in && clk_en_in
      |=> state_out == ST_UNATT_SNK && cc_term_out == TERM_PULLDOWN)
      else $error("dual-role detach missed");
   a_try_pullup: assert property (
      state_out == ST_TRY_SRC |-> cc_term_out == TERM_PULLUP && !vbus_en_out)
      else $error("try source term wrong");
   c_att_src: cover property (state_out == ST_ATT_SRC);
   c_att_snk: cover property (state_out == ST_ATT_SNK);
   c_try_src: cover property (state_out == ST_TRY_SRC);
   c_try_snk: cover property (state_out == ST_TRY_SNK);
endmodule

bind cc_port_conn cc_port_conn_sva #(
   .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
   .TOGGLE_CYCLES(TOGGLE_CYCLES)
) chk (
   .clk_in, .rst_n_in, .clk_en_in, .port_kind_in, .try_mode_in, .usb2_simple_in,
   .cc_pulldown_seen_in, .cc_pullup_seen_in, .cc_rd_level_in, .vbus_present_in, .rp_limit_in,
   .state_out, .cc_term_out, .rp_level_out, .sink_current_out, .vbus_en_out, .vconn_en_out,
   .attached_out
);

// >>> verification/test_cc_port_conn.sv
// Self-checking bench for the port connection state machine.
// Assumes the far port model and the bound checker.
`timescale 1ns/1ps
module test_cc_port_conn
   import cc_conn_pkg::*;
;
   localparam int unsigned DEB = 16;
   localparam int unsigned TOG = 24;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic clk_en_in = 1'b1;
   logic [1:0] port_kind_in = KIND_DRP;
   logic [1:0] try_mode_in = TRY_NONE;
   logic usb2_simple_in = 1'b0;
   logic [1:0] rp_limit_in = 2'h0;
   logic plug = 1'b0;
   logic src_role = 1'b0;
   logic supply = 1'b1;
   logic [1:0] level = 2'h0;
   logic cc_pulldown_seen_in;
   logic cc_pullup_seen_in;
   logic vbus_present_in;
   logic [1:0] cc_rd_level_in;
   logic [3:0] state_out;
   logic [1:0] cc_term_out;
   logic [1:0] rp_level_out;
   logic [1:0] sink_current_out;
   logic vbus_en_out;
   logic vconn_en_out;
   logic attached_out;
   int n_fail = 0;
   int n_checks = 0;
   int took;

   always #12.5 clk_in = ~clk_in;

   cc_port_conn #(.DEBOUNCE_CYCLES(DEB), .TOGGLE_CYCLES(TOG)) dut (
      .clk_in, .rst_n_in, .clk_en_in, .port_kind_in, .try_mode_in, .usb2_simple_in,
      .cc_pulldown_seen_in, .cc_pullup_seen_in, .cc_rd_level_in, .vbus_present_in, .rp_limit_in,
      .state_out, .cc_term_out, .rp_level_out, .sink_current_out, .vbus_en_out, .vconn_en_out,
      .attached_out
   );
   cc_far_port far (
      .clk_in, .rst_n_in, .plug_in(plug), .src_role_in(src_role), .supply_in(supply),
      .level_in(level), .dut_term_in(cc_term_out), .pulldown_out(cc_pulldown_seen_in),
      .pullup_out(cc_pullup_seen_in), .vbus_out(vbus_present_in), .rd_level_out(cc_rd_level_in)
   );
   ////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (exp !== got) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask
   // Bounded wait; a miss ends the run rather than hanging it
   task automatic wait_state(input logic [3:0] target, input int bound);
      took = 0;
      while (state_out !== target && took < bound) begin
         step(1);
         took++;
      end
      chk("state", target, state_out);
      if (state_out !== target) end_of_test();
   endtask
   task automatic reset_as(input logic [1:0] kind);
      rst_n_in = 1'b0;
      port_kind_in = kind;
      step(2);
      rst_n_in = 1'b1;
   endtask
   ////////////////////////////////////////
   task automatic s_toggle();
      chk("reset term", TERM_PULLDOWN, cc_term_out);
      wait_state(ST_UNATT_SRC, TOG + 4);
      wait_state(ST_UNATT_SNK, TOG + 4);
      clk_en_in = 1'b0;
      step(3 * TOG);
      chk("frozen", ST_UNATT_SNK, state_out);
      clk_en_in = 1'b1;
   endtask
   task automatic s_drp_source();
      plug = 1'b1;
      wait_state(ST_WAIT_SRC, 2 * TOG + 4);
      wait_state(ST_ATT_SRC, DEB + 4);
      // Source wait re-samples the pull-down for one edge before counting
      chk("debounce", 16'(DEB + 2), 16'(took));
      chk("supplies", 3'h7, {vbus_en_out, vconn_en_out, attached_out});
      for (int i = 0; i < 4; i++) begin
         rp_limit_in = 2'(i);
         step(2);
         chk("rp", 16'(i), rp_level_out);
      end
      plug = 1'b0;
      step(1);
      chk("detach", ST_UNATT_SNK, state_out);
      chk("term", TERM_PULLDOWN, cc_term_out);
      chk("off", 2'h0, {vbus_en_out, vconn_en_out});
      wait_state(ST_UNATT_SRC, TOG + 4);
   endtask
   task automatic s_drp_sink();
      try_mode_in = 2'h3;
      src_role = 1'b1;
      plug = 1'b1;
      wait_state(ST_WAIT_SNK, 2 * TOG + 4);
      wait_state(ST_ATT_SNK, DEB + 8);
      chk("snk debounce", 16'(DEB + 1), 16'(took));
      for (int i = 0; i < 4; i++) begin
         level = 2'(i);
         step(2);
         chk("vrd", 16'(i), sink_current_out);
      end
      supply = 1'b0;
      step(2);
      chk("vbus loss", ST_UNATT_SNK, state_out);
      plug = 1'b0;
      supply = 1'b1;
      try_mode_in = TRY_SRC;
      step(4);
   endtask
   task automatic s_try_src();
      plug = 1'b1;
      wait_state(ST_TRY_SRC, 2 * TOG + DEB + 8);
      chk("try term", TERM_PULLUP, cc_term_out);
      wait_state(ST_ATT_SRC, 8);
      chk("supplies", 3'h7, {vbus_en_out, vconn_en_out, attached_out});
      plug = 1'b0;
      try_mode_in = TRY_NONE;
      src_role = 1'b0;
   endtask
   task automatic s_src_only();
      reset_as(KIND_SRC);
      wait_state(ST_UNATT_SRC, 4);
      plug = 1'b1;
      wait_state(ST_ATT_SRC, DEB + 6);
      plug = 1'b0;
      step(1);
      chk("src detach", ST_UNATT_SRC, state_out);
   endtask
   task automatic s_usb2_sink();
      usb2_simple_in = 1'b1;
      reset_as(KIND_SNK);
      src_role = 1'b1;
      plug = 1'b1;
      wait_state(ST_ATT_SNK, DEB / 2);
   endtask
   task automatic s_try_snk();
      plug = 1'b0;
      usb2_simple_in = 1'b0;
      reset_as(KIND_DRP);
      src_role = 1'b0;
      try_mode_in = TRY_SNK;
      plug = 1'b1;
      wait_state(ST_TRY_SNK, 2 * TOG + DEB + 8);
      chk("try snk term", TERM_PULLDOWN, cc_term_out);
      chk("try snk off", 2'h0, {vbus_en_out, vconn_en_out});
      wait_state(ST_UNATT_SRC, TOG + 4);
   endtask
   initial begin
      step(12);
      rst_n_in = 1'b1;
      s_toggle();
      s_drp_source();
      s_drp_sink();
      s_try_src();
      s_src_only();
      s_usb2_sink();
      s_try_snk();
      end_of_test();
   end
endmodule

// >>> verilog/cc_debounce.sv
// Debounce counter: reports a condition once stable for a set number of cycles.
// Assumes inputs synchronous to clk_in.
`timescale 1ns/1ps
module cc_debounce
   import cc_conn_pkg::*;
#(
   parameter int unsigned CYCLES = DEBOUNCE_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic en_in,
   input wire logic restart_in,
   input wire logic cond_in,
   output logic stable_out
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic cond_q;
   logic cond_d;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      cond_d = cond_in;
      cnt_d = cnt_q;
      // Any change of the watched level starts the interval again [R17]
      if (restart_in || (cond_in != cond_q) || !cond_in) begin
         cnt_d = '0;
      end else if (cnt_q < CNT_W'(CYCLES)) begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
         cond_q <= 1'b0;
      end else if (en_in) begin
         cnt_q <= cnt_d;
         cond_q <= cond_d;
      end
   end

   assign stable_out = (cnt_q >= CNT_W'(CYCLES)) && cond_in;
endmodule

// >>> verilog/cc_port_conn.sv
// Connection-detection state machine for a reversible port (source, sink or dual-role).
// Assumes CC/VBUS sense inputs already conditioned and synchronous to clk_in.
// Outputs are registered and change on the edge that enters a state.
//
// Overview of operation
// (R1) Unattached dual-role port alternates sink and source until termination seen.
// (R2) Source seeing pull-down waits, attaches after debounce of that pull-down.
// (R3) Entering attached source turns on VBUS and VCONN.
// (R4) Simple USB 2.0 sink may go straight to attached on VBUS.
// (R5) Sink seeing pull-up waits; attaches after debounce plus VBUS present.
// (R6) Attached source sets Rp level to cap sink current.
// (R7) Attached sink keeps reading vRd level to learn available current.
// (R8) Source-only port returns to unattached source on CC removal.
// (R9) Attached sink detaches on VBUS loss, returning to unattached sink.
// (R10) Dual-role port goes to unattached sink on detach, then toggles.
// (R11) Source-preferring dual-role port goes to try-source instead of sink attach.
// (R12) In try-source present pull-up and wait for partner role reversal.
// (R13) Dual-role attached source losing pull-down falls back to unattached sink.
// (R14) Leaving source role removes VBUS, VCONN and presents pull-down.
// (R15) Try-source seeing pull-down attaches as source, enabling VBUS and VCONN.
// (R16) Try-source and try-sink never both enabled; chosen while unattached.
// (R17) Debounce is a cycle-count parameter, restarting on any CC change.
`timescale 1ns/1ps
module cc_port_conn
   import cc_conn_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int unsigned TOGGLE_CYCLES = TOGGLE_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire logic [1:0] port_kind_in,
   input wire logic [1:0] try_mode_in,
   input wire logic usb2_simple_in,
   input wire logic cc_pulldown_seen_in,
   input wire logic cc_pullup_seen_in,
   input wire logic [1:0] cc_rd_level_in,
   input wire logic vbus_present_in,
   input wire logic [1:0] rp_limit_in,
   output logic [3:0] state_out,
   output logic [1:0] cc_term_out,
   output logic [1:0] rp_level_out,
   output logic [1:0] sink_current_out,
   output logic vbus_en_out,
   output logic vconn_en_out,
   output logic attached_out
);
   conn_state_t st_q;
   conn_state_t st_d;
   logic [1:0] try_q;
   logic [1:0] try_d;
   logic [1:0] term_d;
   logic [1:0] term_q;
   logic [1:0] rp_d;
   logic [1:0] rp_q;
   logic [1:0] cur_d;
   logic [1:0] cur_q;
   logic vbus_d;
   logic vbus_q;
   logic vconn_d;
   logic vconn_q;
   logic att_d;
   logic att_q;
   logic is_drp;
   logic is_src_only;
   logic is_snk_only;
   logic state_change;
   logic deb_cond;
   logic deb_ok;
   logic tgl_tick;

   ////////////////////////////////////////////////////////////////////////
   // Reserved kind code acts as sink-only, the role that drives no supply
   always_comb begin
      is_drp = 1'b0;
      is_src_only = 1'b0;
      is_snk_only = 1'b0;
      case (port_kind_in)
         KIND_SRC: begin
            is_src_only = 1'b1;
         end
         KIND_SNK: begin
            is_snk_only = 1'b1;
         end
         KIND_DRP: begin
            is_drp = 1'b1;
         end
         default: begin
            is_snk_only = 1'b1;
         end
      endcase
   end

   assign state_change = (st_d != st_q);

   ////////////////////////////////////////////////////////////////////////
   // Debounce watches the partner termination relevant to the current role
   // One counter serves both wait states, as only one of them is live at a time
   assign deb_cond = (st_q == ST_WAIT_SRC) ? cc_pulldown_seen_in : cc_pullup_seen_in;

   cc_debounce #(
      .CYCLES(DEBOUNCE_CYCLES)
   ) u_deb (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .en_in(clk_en_in),
      .restart_in(state_change),
      .cond_in(deb_cond),
      .stable_out(deb_ok)
   );

   // Dwell restarts on every state change, so each role gets a full window
   cc_toggle_timer #(
      .CYCLES(TOGGLE_CYCLES)
   ) u_tgl (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .en_in(clk_en_in),
      .restart_in(state_change),
      .tick_out(tgl_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Try mechanism: one choice only, latched while unattached [R16]
   always_comb begin
      try_d = try_q;
      if (st_q == ST_UNATT_SNK || st_q == ST_UNATT_SRC) begin
         try_d = is_drp ? try_mode_in : TRY_NONE; // [R16]
         if (try_mode_in == (TRY_SRC | TRY_SNK)) begin
            try_d = TRY_NONE; // Both requested is illegal, use neither [R16]
         end
      end
   end

   // Held through attach so a late strap change cannot flip an agreed role
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         try_q <= TRY_NONE;
      end else if (clk_en_in) begin
         try_q <= try_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_UNATT_SNK: begin
            if (is_src_only) begin
               st_d = ST_UNATT_SRC;
            end else if (usb2_simple_in && is_snk_only) begin
               // Simple sink waits on VBUS alone; the pull-up comes well before it
               if (vbus_present_in) begin
                  st_d = ST_ATT_SNK; // [R4]
               end
            end else if (cc_pullup_seen_in) begin
               st_d = ST_WAIT_SNK; // [R5]
            end else if (is_drp && tgl_tick) begin
               st_d = ST_UNATT_SRC; // [R1]
            end
         end
         ST_WAIT_SNK: begin
            if (!cc_pullup_seen_in && !vbus_present_in) begin
               st_d = is_drp ? ST_UNATT_SRC : ST_UNATT_SNK;
            end else if (deb_ok && vbus_present_in) begin
               // Source-preferring dual-role port tries to flip the result [R11]
               st_d = (try_q == TRY_SRC) ? ST_TRY_SRC : ST_ATT_SNK; // [R5]
            end
         end
         ST_ATT_SNK: begin
            if (!vbus_present_in) begin
               st_d = ST_UNATT_SNK; // [R9] [R10]
            end
         end
         ST_UNATT_SRC: begin
            if (is_snk_only) begin
               st_d = ST_UNATT_SNK;
            end else if (cc_pulldown_seen_in) begin
               st_d = ST_WAIT_SRC; // [R2]
            end else if (is_drp && tgl_tick) begin
               st_d = ST_UNATT_SNK; // [R1]
            end
         end
         ST_WAIT_SRC: begin
            if (!cc_pulldown_seen_in) begin
               st_d = is_drp ? ST_UNATT_SNK : ST_UNATT_SRC;
            end else if (deb_ok) begin
               st_d = (try_q == TRY_SNK) ? ST_TRY_SNK : ST_ATT_SRC; // [R2]
            end
         end
         ST_ATT_SRC: begin
            if (!cc_pulldown_seen_in) begin
               // Dual-role falls back to sink, source-only stays a source
               st_d = is_drp ? ST_UNATT_SNK : ST_UNATT_SRC; // [R8] [R13] [R10]
            end
         end
         ST_TRY_SRC: begin
            if (cc_pulldown_seen_in) begin
               st_d = ST_ATT_SRC; // [R15]
            end else if (tgl_tick && !cc_pullup_seen_in) begin
               // Partner pull-up gone at a dwell tick; give up rather than hang here
               st_d = ST_UNATT_SNK;
            end
         end
         ST_TRY_SNK: begin
            // Sink-preferring port holds pull-down until the partner sources VBUS, or until a dwell tick with no pull-up seen [R16]
            if (vbus_present_in && cc_pullup_seen_in) begin
               st_d = ST_ATT_SNK;
            end else if (tgl_tick && !cc_pullup_seen_in) begin
               st_d = ST_UNATT_SRC;
            end
         end
         default: begin
            st_d = ST_UNATT_SNK;
         end
      endcase
   end

   // State shares the enable with the outputs so a frozen port stays consistent
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= ST_UNATT_SNK;
      end else if (clk_en_in) begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs derive from the next state so they change with the entry edge
   always_comb begin
      term_d = TERM_PULLDOWN;
      vbus_d = 1'b0;
      vconn_d = 1'b0;
      att_d = 1'b0;
      case (st_d)
         ST_UNATT_SRC, ST_WAIT_SRC: begin
            term_d = TERM_PULLUP;
         end
         ST_TRY_SRC: begin
            term_d = TERM_PULLUP; // [R12]
         end
         ST_ATT_SRC: begin
            term_d = TERM_PULLUP;
            vbus_d = 1'b1; // [R3] [R15]
            vconn_d = 1'b1; // [R3] [R15]
            att_d = 1'b1;
         end
         ST_ATT_SNK: begin
            att_d = 1'b1;
         end
         default: begin
            // Sink-side states drop supplies and present pull-down [R14]
            term_d = TERM_PULLDOWN;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         term_q <= TERM_PULLDOWN;
         vbus_q <= 1'b0;
         vconn_q <= 1'b0;
         att_q <= 1'b0;
      end else if (clk_en_in) begin
         term_q <= term_d;
         vbus_q <= vbus_d;
         vconn_q <= vconn_d;
         att_q <= att_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Current levels: Rp keeps its last setting once the source role ends
   always_comb begin
      rp_d = rp_q;
      cur_d = 2'h0;
      if (st_d == ST_ATT_SRC) begin
         rp_d = rp_limit_in; // [R6]
      end
      if (st_d == ST_ATT_SNK) begin
         cur_d = cc_rd_level_in; // [R7]
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rp_q <= 2'h0;
         cur_q <= 2'h0;
      end else if (clk_en_in) begin
         rp_q <= rp_d;
         cur_q <= cur_d;
      end
   end

   assign state_out = st_q;
   assign cc_term_out = term_q;
   assign rp_level_out = rp_q;
   assign sink_current_out = cur_q;
   assign vbus_en_out = vbus_q;
   assign vconn_en_out = vconn_q;
   assign attached_out = att_q;
endmodule

// >>> verilog/cc_toggle_timer.sv
// Free-running dwell timer giving a one-cycle tick for role toggling.
// Assumes inputs synchronous to clk_in.
`timescale 1ns/1ps
module cc_toggle_timer
   import cc_conn_pkg::*;
#(
   parameter int unsigned CYCLES = TOGGLE_CYC
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic en_in,
   input wire logic restart_in,
   output logic tick_out
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      cnt_d = cnt_q + CNT_W'(1);
      if (restart_in || tick_out) begin
         cnt_d = '0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
      end else if (en_in) begin
         cnt_q <= cnt_d;
      end
   end

   assign tick_out = (cnt_q >= CNT_W'(CYCLES - 1));
endmodule
